// >>> src/nls_pkg.sv
package nls_pkg;
  // printed offset 0x52 is not a word multiple: offsets kept as indices, byte address = 4 * index
  localparam logic [7:0] LINK_STATUS_IDX = 8'h52;
  localparam logic [7:0] SLOT_CAP_IDX = 8'h54;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h60;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h61;
  localparam logic [7:0] STRAP_CTRL_IDX = 8'h62;
  localparam logic [11:0] LINK_STATUS_ADDR = {2'h0, LINK_STATUS_IDX, 2'h0};
  localparam logic [11:0] SLOT_CAP_ADDR = {2'h0, SLOT_CAP_IDX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [11:0] STRAP_CTRL_ADDR = {2'h0, STRAP_CTRL_IDX, 2'h0};
  localparam logic [3:0] LINK_RATE_CODE = 4'h1;
  localparam int RATE_LSB = 0;
  localparam int LANE_LSB = 4;
  localparam int FAULT_BIT = 10;
  localparam int TRAIN_BIT = 11;
  localparam int REFCLK_BIT = 12;
  localparam int BAY_LSB = 19;
  localparam logic [12:0] BAY_RESET = 13'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_TRAIN_DONE = 1;
  localparam int IRQ_TRAIN_START = 2;
  localparam int LOCK_BIT = 0;
  localparam int LOCK_DONE_BIT = 1;
  localparam int SYNC_DEPTH = 3;
  // edges until the strap synchroniser has settled
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  typedef struct packed {
    logic [5:0] negotiated_lane_count;
    logic train_fault_flag;
    logic train_active_flag;
  } nls_link_s;

  typedef struct packed {
    logic valid;
    logic value;
  } nls_eeprom_s;
endpackage

// >>> src/nls_regs.sv
//
// Contract
// - Link status bits 3:0 always read 0x1, the fixed 2.5 Gbps rate.
// - Link status bits 9:4 show the negotiated lane count given by hardware.
// - Link status bit 10 is read-only, high while a training error is reported, zero from reset.
// - Link status bit 11 is read-only, high while training runs, zero from reset.
// - Link status bit 12 set means the port shares the platform reference clock.
// - Bit 12 takes its initial value from the downstream common-clock strap.
// - A value loaded from serial EEPROM may replace the strap-derived bit 12.
// - Slot capability bits 0 to 6 read zero: no hot-plug features.
// - Slot power limit value 14:7 and scale 16:15 read zero.
// - Slot capability bits 17 and 18 read zero.
// - Slot capability bits 31:19 hold a 13-bit slot number, writable while unlocked, reset zero.
// - The slot number is read-only and reads zero while the slot-implemented bit is clear.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module nls_regs
  import nls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic downstream_common_refclk_strap,
  input wire nls_eeprom_s eeprom_refclk,
  input wire nls_link_s link_state,
  input wire logic slot_implemented,
  output logic irq
);
  logic strap_level;
  logic refclk;
  logic strap_taken;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic [12:0] physical_bay_index;
  logic lockable_write;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic train_prev;
  logic fault_prev;
  logic next_refclk;
  logic next_strap_taken;
  logic [12:0] next_bay;
  logic next_lock;
  logic [2:0] next_irq_status;
  logic [2:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic [2:0] events;
  logic wr_en;
  logic rd_en;

  nls_sync u_strap_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(downstream_common_refclk_strap),
    .level(strap_level)
  );

  function automatic logic [31:0] link_word(input nls_link_s ls, input logic rc);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RATE_LSB +: 4] = LINK_RATE_CODE;
    w[LANE_LSB +: 6] = ls.negotiated_lane_count;
    w[FAULT_BIT] = ls.train_fault_flag;
    w[TRAIN_BIT] = ls.train_active_flag;
    w[REFCLK_BIT] = rc;
    return w;
  endfunction

  function automatic logic [31:0] slot_word(input logic [12:0] bay, input logic impl);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BAY_LSB +: 13] = impl ? bay : 13'h0000;
    return w;
  endfunction

  // write lands at the edge that completes the transfer
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable;
  assign events = {link_state.train_active_flag && !train_prev,
                   !link_state.train_active_flag && train_prev,
                   link_state.train_fault_flag && !fault_prev};

  always_comb begin
    next_refclk = refclk;
    next_settle = settle;
    // strap taken only once the synchroniser has filled
    next_strap_taken = strap_taken || (settle == STRAP_SETTLE);
    next_bay = physical_bay_index;
    next_lock = lockable_write;
    next_irq_mask = irq_mask;
    // set wins over write-one-to-clear
    next_irq_status = irq_status;
    if (!strap_taken) begin
      next_refclk = strap_level;
      next_settle = 3'(settle + 3'h1);
    end
    if (eeprom_refclk.valid) begin
      next_refclk = eeprom_refclk.value;
    end
    if (wr_en) begin
      case (paddr)
        LINK_STATUS_ADDR: begin
          if (!lockable_write && pstrb[1]) begin
            next_refclk = pwdata[REFCLK_BIT];
          end
        end
        SLOT_CAP_ADDR: begin
          if (!lockable_write && slot_implemented && (&pstrb[3:2])) begin
            next_bay = pwdata[BAY_LSB +: 13];
          end
        end
        IRQ_STATUS_ADDR: begin
          if (pstrb[0]) begin
            next_irq_status = irq_status & ~pwdata[2:0];
          end
        end
        IRQ_MASK_ADDR: begin
          if (pstrb[0]) begin
            next_irq_mask = pwdata[2:0];
          end
        end
        STRAP_CTRL_ADDR: begin
          // lock is sticky until reset
          if (pstrb[0] && pwdata[LOCK_BIT]) begin
            next_lock = 1'b1;
          end
        end
        default: begin
          next_lock = lockable_write;
        end
      endcase
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // one wait state: setup, access, ready
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (rd_en) begin
      case (paddr)
        LINK_STATUS_ADDR: next_prdata = link_word(link_state, refclk);
        SLOT_CAP_ADDR: next_prdata = slot_word(physical_bay_index, slot_implemented);
        IRQ_STATUS_ADDR: next_prdata = {29'h0, irq_status};
        IRQ_MASK_ADDR: next_prdata = {29'h0, irq_mask};
        STRAP_CTRL_ADDR: next_prdata = {30'h0, strap_taken, lockable_write};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && !pready) begin
      case (paddr)
        LINK_STATUS_ADDR, SLOT_CAP_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, STRAP_CTRL_ADDR: next_pslverr = 1'b0;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      refclk <= 1'b0;
      strap_taken <= 1'b0;
      settle <= 3'h0;
      physical_bay_index <= BAY_RESET;
      lockable_write <= 1'b0;
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      train_prev <= 1'b0;
      fault_prev <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      refclk <= next_refclk;
      strap_taken <= next_strap_taken;
      settle <= next_settle;
      physical_bay_index <= next_bay;
      lockable_write <= next_lock;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      train_prev <= link_state.train_active_flag;
      fault_prev <= link_state.train_fault_flag;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  rate_fixed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && !pwrite && paddr == LINK_STATUS_ADDR) |-> prdata[3:0] == 4'h1)
    else $error("link rate code not 0x1");
  lane_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_en && paddr == LINK_STATUS_ADDR) |=> prdata[9:4] == $past(link_state.negotiated_lane_count))
    else $error("lane count mismatch");
  fault_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_en && paddr == LINK_STATUS_ADDR) |=> prdata[10] == $past(link_state.train_fault_flag))
    else $error("training fault bit mismatch");
  train_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_en && paddr == LINK_STATUS_ADDR) |=> prdata[11] == $past(link_state.train_active_flag))
    else $error("training active bit mismatch");
  refclk_locked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (strap_taken && lockable_write && !eeprom_refclk.valid) |=> $stable(refclk))
    else $error("refclk bit changed while locked");
  strap_seed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!strap_taken && !eeprom_refclk.valid && !wr_en) |=> refclk == $past(strap_level))
    else $error("refclk bit not taken from strap");
  eeprom_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (eeprom_refclk.valid && !wr_en) |=> refclk == $past(eeprom_refclk.value))
    else $error("eeprom value not loaded");
  slot_fixed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && paddr == SLOT_CAP_ADDR) |-> prdata[18:0] == 19'h00000)
    else $error("slot capability low bits not zero");
  power_cap_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && paddr == SLOT_CAP_ADDR) |-> prdata[16:7] == 10'h000)
    else $error("slot power limit not zero");
  interlock_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && paddr == SLOT_CAP_ADDR) |-> prdata[18:17] == 2'h0)
    else $error("slot bits 18:17 not zero");
  bay_locked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    lockable_write |=> $stable(physical_bay_index))
    else $error("slot number changed while locked");
  bay_write_only_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(wr_en && paddr == SLOT_CAP_ADDR) |=> $stable(physical_bay_index))
    else $error("slot number changed without a write");
  no_slot_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_en && paddr == SLOT_CAP_ADDR && !slot_implemented) |=> prdata[31:19] == 13'h0000)
    else $error("slot number not zero without slot");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && paddr == LINK_STATUS_ADDR) |-> prdata[31:13] == 19'h00000)
    else $error("reserved link status bits not zero");
  lock_sticky_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    lockable_write |=> lockable_write)
    else $error("lock cleared before reset");
  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pslverr |-> pready)
    else $error("error response without ready");
  err_data_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pready && pslverr) |-> prdata == 32'h0000_0000)
    else $error("error response with nonzero data");
  // an event must survive a same-cycle clear
  train_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (link_state.train_active_flag && !train_prev) |=> irq_status[IRQ_TRAIN_START])
    else $error("training start event lost");
  train_done_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!link_state.train_active_flag && train_prev) |=> irq_status[IRQ_TRAIN_DONE])
    else $error("training end event lost");
  fault_event_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (link_state.train_fault_flag && !fault_prev) |=> irq_status[IRQ_FAULT])
    else $error("training fault event lost");

  read_link_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    pready && !pwrite && paddr == LINK_STATUS_ADDR);
  read_train_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    pready && paddr == LINK_STATUS_ADDR && prdata[TRAIN_BIT]);
  write_bay_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en && paddr == SLOT_CAP_ADDR && !lockable_write);
  lock_set_c: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(lockable_write));
  irq_fire_c: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(irq));
endmodule

// >>> src/nls_sync.sv
`timescale 1ns/10ps
module nls_sync
  import nls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic pin,
  output logic level
);
  logic [SYNC_DEPTH-1:0] stage;
  logic next_level;

  // a change counts once stages two and three agree
  always_comb begin
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      level <= 1'b0;
    end else begin
      stage <= {stage[SYNC_DEPTH-2:0], pin};
      level <= next_level;
    end
  end
endmodule

// >>> verification/nls_link_partner.sv
`timescale 1ns/10ps
module nls_link_partner
  import nls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [5:0] lanes,
  input wire logic fault,
  input wire logic [7:0] dly,
  output nls_link_s link_state
);
  logic [7:0] cnt;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      link_state <= '0;
      cnt <= 8'h0;
    end else if (go) begin
      link_state.train_active_flag <= 1'b1;
      cnt <= dly;
    end else if (link_state.train_active_flag) begin
      cnt <= cnt - 8'h1;
      if (cnt == 8'h0) link_state <= '{lanes, fault, 1'b0};
    end
  end
endmodule

// >>> verification/tb_ntb_port_link_slot_status.sv
`timescale 1ns/10ps
module tb_ntb_port_link_slot_status
  import nls_pkg::*;
;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, irq, strap, slot_impl, go, flt, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [5:0] lanes;
  logic [7:0] dly;
  nls_eeprom_s eep;
  nls_link_s link;
  int errors, n_tests, seed, lk, ref_m, bay, ist, msk, m_ln, m_ft;
  nls_regs u_nls_regs(.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .downstream_common_refclk_strap(strap), .eeprom_refclk(eep), .link_state(link),
    .slot_implemented(slot_impl), .irq(irq));
  nls_link_partner u_nls_link_partner(.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .lanes(lanes),
    .fault(flt), .dly(dly), .link_state(link));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // wait on pready, bounded; master holds everything until then
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    n = 0;
    do begin
      @(posedge clk_sys);
      penable <= 1'b1;
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == LINK_STATUS_ADDR && lk == 0 && s[1] && !eep.valid) ref_m = d[REFCLK_BIT];
    if (w && a == SLOT_CAP_ADDR && lk == 0 && s[3] && s[2] && slot_impl) bay = d[31:19];
    if (w && a == IRQ_STATUS_ADDR) ist &= ~d[2:0];
    if (w && a == IRQ_MASK_ADDR) msk = d[2:0];
    if (w && a == STRAP_CTRL_ADDR && d[LOCK_BIT]) lk = 1;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    chk("irq", {31'h0, |(ist[2:0] & msk[2:0])}, {31'h0, irq});
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
    chk("slverr", 32'h0, {31'h0, er});
  endtask
  function automatic logic [31:0] exp_ls();
    return {16'h0, 3'h0, ref_m[0], 1'b0, m_ft[0], m_ln[5:0], LINK_RATE_CODE};
  endfunction
  function automatic logic [31:0] exp_sc();
    return slot_impl ? {bay[12:0], 19'h0} : 32'h0;
  endfunction
  // slow or prompt training by random delay
  task automatic train(input logic f);
    int n;
    @(posedge clk_sys);
    lanes <= 6'($random(seed));
    dly <= 8'($random(seed) & 15);
    flt <= f;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    n = 0;
    while (link.train_active_flag === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    ist |= 6;
    if (f && m_ft == 0) ist |= 1;
    m_ft = f;
    m_ln = lanes;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
  initial begin
    seed = 57;
    {errors, n_tests, lk, bay, ist, msk, m_ln, m_ft} = '0;
    ref_m = 1;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb, go, flt, lanes, dly, eep} = '0;
    strap = 1'b1;
    slot_impl = 1'b1;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc("link", LINK_STATUS_ADDR, exp_ls());
    rdc("slot", SLOT_CAP_ADDR, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      train(i[2]);
      apb(1'b1, IRQ_MASK_ADDR, $random(seed), 4'hF);
      rdc("irq_status", IRQ_STATUS_ADDR, ist);
      apb(1'b1, IRQ_STATUS_ADDR, $random(seed), 4'hF);
      apb(1'b1, LINK_STATUS_ADDR, $random(seed), 4'($random(seed)));
      rdc("link", LINK_STATUS_ADDR, exp_ls());
      apb(1'b1, SLOT_CAP_ADDR, $random(seed), 4'($random(seed)));
      rdc("slot", SLOT_CAP_ADDR, exp_sc());
    end
    $display("test random done");
    dly <= 8'h40;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    ist |= 4;
    rdc("link_train", LINK_STATUS_ADDR, exp_ls() | (32'h0000_0001 << TRAIN_BIT));
    for (int n = 0; n < 100 && link.train_active_flag === 1'b1; n++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    ist |= 2;
    $display("test training done");
    for (int v = 0; v < 2; v++) begin
      eep <= '{1'b1, v[0]};
      ref_m = v;
      rdc("link_eeprom", LINK_STATUS_ADDR, exp_ls());
    end
    eep <= '0;
    $display("test eeprom done");
    slot_impl <= 1'b0;
    apb(1'b1, SLOT_CAP_ADDR, 32'hFFFFFFFF, 4'hF);
    rdc("slot_none", SLOT_CAP_ADDR, exp_sc());
    slot_impl <= 1'b1;
    @(posedge clk_sys);
    rdc("slot_kept", SLOT_CAP_ADDR, exp_sc());
    apb(1'b1, SLOT_CAP_ADDR, 32'h0, 4'hF);
    rdc("slot_zero", SLOT_CAP_ADDR, exp_sc());
    $display("test slot done");
    apb(1'b1, STRAP_CTRL_ADDR, 32'h1, 4'hF);
    apb(1'b1, SLOT_CAP_ADDR, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, LINK_STATUS_ADDR, 32'h0, 4'hF);
    rdc("slot_lock", SLOT_CAP_ADDR, exp_sc());
    rdc("link_lock", LINK_STATUS_ADDR, exp_ls());
    $display("test lock done");
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
